// ---- ipm_ctrl.v ----
// Interrupt masking, external pin conditioning and power mode sequencing.
`timescale 1ns/1ps
`include "ipm_defines.vh"

// How it works
// RULE1: Watchdog action bit picks interrupt flag at 0, internal reset pulse at 1.
// RULE2: Global enable cleared by disable instruction or entry, set by enable or return.
// RULE3: Two-bit watchdog ratio code selects 1:4, 1:16, 1:64 or 1:256.
// RULE4: Watchdog enable bit turns the watchdog on at 1, off at 0.
// RULE5: Three-bit timer ratio code selects 1:2 doubling up to 1:256.
// RULE6: Pin one filter drops pulses below 63 clocks, or 15 when selected.
// RULE7: Pin zero enable makes the pin a falling-edge interrupt, else plain I/O.
// RULE8: Pin three edge code: rising, falling, both; code three never triggers.
// RULE9: Pin one edge bit selects rising at 0, falling at 1.
// RULE10: Pin three always drops pulses shorter than 7 clocks.
// RULE11: First mask register enables its seven sources; bit 4 reads zero.
// RULE12: Second mask register enables its six sources; bits 7 and 1 read zero.
// RULE13: Pin five raises a request only while its mask bit is set.
// RULE14: Power-down instruction enters Sleep if sleep select is 1, else Idle.
// RULE15: Idle halts the core only; any unmasked pending source returns to Normal.
// RULE16: After Idle wake the core is vectored first only when global enable is set.
// RULE17: Sleep stops the oscillator; only pin five wakes it, by level or edge.
// RULE18: Sleep wake waits a warm-up period before execution resumes.
// RULE19: In level wake mode the outside holds pin five low before Sleep.
// RULE20: In edge wake mode Sleep is entered even while pin five is high.
// RULE21: Reset releases Idle or Sleep through a full reset.
// RULE22: Flags latch even when no wake or vector follows.
// RULE23: Request needs flag, mask and global enable; Idle wake needs flag and mask.
// RULE24: Warm-up length is a parameter counted in oscillator cycles.
module ipm_ctrl #(
  parameter WARM_CYCLES = `IPM_WARM_CYCLES
) (
  input  wire             core_clk,
  input  wire             sys_rst,
  input  wire [4:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [7:0]       reg_rdata,
  input  wire             irq_on_instruction,
  input  wire             irq_off_instruction,
  input  wire             irq_return_instruction,
  input  wire             power_down_instruction,
  input  wire             irq_entry,
  input  wire [7:0]       periph_evt_first,
  input  wire [7:0]       periph_evt_second,
  input  wire             wdt_timeout,
  input  wire             ext_zero_pin_n,
  input  wire             ext_one_pin,
  input  wire             ext_three_pin,
  input  wire             ext_five_pin_n,
  output wire             irq_req,
  output wire             global_irq_en,
  output reg              wdt_reset_req,
  output wire             watchdog_on,
  output wire [3:0]       watchdog_div_log2,
  output wire [3:0]       timer_div_log2,
  output wire             ext_zero_pin_enable,
  output wire [2:0]       clock_source_sel,
  output wire             core_halt,
  output wire             osc_run,
  output wire             periph_run
);

  reg  [7:0]              core_reg;
  reg  [7:0]              mode_reg;
  reg  [7:0]              ext_reg;
  reg  [7:0]              mask1_reg;
  reg  [7:0]              mask2_reg;
  reg  [7:0]              flag1_reg;
  reg  [7:0]              flag2_reg;
  reg  [7:0]              flag3_reg;
  reg  [3:0]              sync1_reg;
  reg  [3:0]              sync2_reg;
  reg  [3:0]              prev_reg;
  reg                     one_lvl_reg;
  reg                     one_prev_reg;
  reg  [5:0]              one_cnt_reg;
  reg                     three_lvl_reg;
  reg                     three_prev_reg;
  reg  [5:0]              three_cnt_reg;
  reg  [1:0]              state_reg;
  reg  [1:0]              state_next;
  reg  [`IPM_WARM_W-1:0]  warm_reg;
  reg  [`IPM_WARM_W-1:0]  warm_next;
  reg                     gie_next;
  reg  [7:0]              flag1_next;
  reg  [7:0]              flag2_next;
  reg  [7:0]              flag3_next;
  reg  [7:0]              set1;
  reg  [7:0]              set2;
  reg  [7:0]              set3;
  reg  [7:0]              rd_mux;

  wire [5:0]              one_lim;
  wire                    one_diff;
  wire                    one_take;
  wire                    three_diff;
  wire                    three_take;
  wire                    one_rise;
  wire                    one_fall;
  wire                    three_rise;
  wire                    three_fall;
  wire                    ext_one_evt;
  wire                    ext_three_evt;
  wire                    ext_zero_evt;
  wire                    ext_five_fall;
  wire                    wake_pin;
  wire                    pend_any;
  wire [7:0]              mask3;
  wire [1:0]              three_mode;
  wire                    wr_core;
  wire                    wr_mode;
  wire                    wr_ext;
  wire                    wr_m1;
  wire                    wr_m2;
  wire                    wr_f1;
  wire                    wr_f2;
  wire                    wr_f3;
  wire [`IPM_WARM_W-1:0]  warm_last;

  // The warm-up counter stops on the last cycle of the configured period.
  localparam integer      WARM_LAST_I = WARM_CYCLES - 1;

  // Counts consecutive cycles on which the pin differs from the accepted level.
  function [5:0] flt_next;
    input [5:0] cnt;
    input       diff;
    input [5:0] lim;
    begin
      if (!diff || cnt == lim - 6'h01) begin
        flt_next = 6'h00;
      end else begin
        flt_next = cnt + 6'h01;
      end
    end
  endfunction

  // Keeps unwritten flags, clears written zeros, and lets a new event win.
  function [7:0] flag_next;
    input [7:0] cur;
    input       wr;
    input [7:0] wdata;
    input [7:0] wmask;
    input [7:0] set;
    begin
      if (wr) begin
        flag_next = ((cur & wdata) | set) & wmask;
      end else begin
        flag_next = (cur | set) & wmask;
      end
    end
  endfunction

  assign wr_core = reg_wr && reg_addr == `IPM_A_CORE;
  assign wr_mode = reg_wr && reg_addr == `IPM_A_MODE;
  assign wr_ext  = reg_wr && reg_addr == `IPM_A_EXT;
  assign wr_m1   = reg_wr && reg_addr == `IPM_A_MASK1;
  assign wr_m2   = reg_wr && reg_addr == `IPM_A_MASK2;
  assign wr_f1   = reg_wr && reg_addr == `IPM_A_FLAG1;
  assign wr_f2   = reg_wr && reg_addr == `IPM_A_FLAG2;
  assign wr_f3   = reg_wr && reg_addr == `IPM_A_FLAG3;

  assign global_irq_en       = core_reg[`IPM_CORE_GIE];
  assign watchdog_on         = core_reg[`IPM_CORE_WDT_ON]; // see RULE4
  assign watchdog_div_log2   = {1'b0, core_reg[5:4], 1'b0} + 4'h2; // see RULE3
  assign timer_div_log2      = {1'b0, core_reg[2:0]} + 4'h1; // see RULE5
  assign ext_zero_pin_enable = ext_reg[`IPM_EXT_ZERO_EN]; // see RULE7
  assign clock_source_sel    = mode_reg[6:4];
  assign three_mode          = ext_reg[4:3];

  assign one_lim = ext_reg[`IPM_EXT_ONE_FILT] ? `IPM_FLT_ONE_SHORT : `IPM_FLT_ONE_LONG; // see RULE6
  assign one_diff   = sync2_reg[1] != one_lvl_reg;
  assign one_take   = one_diff && one_cnt_reg == one_lim - 6'h01;
  assign three_diff = sync2_reg[2] != three_lvl_reg;
  assign three_take = three_diff && three_cnt_reg == `IPM_FLT_THREE - 6'h01; // see RULE10

  assign one_rise   = one_lvl_reg && !one_prev_reg;
  assign one_fall   = !one_lvl_reg && one_prev_reg;
  assign three_rise = three_lvl_reg && !three_prev_reg;
  assign three_fall = !three_lvl_reg && three_prev_reg;

  assign ext_one_evt = ext_reg[`IPM_EXT_ONE_EDGE] ? one_fall : one_rise; // see RULE9
  assign ext_three_evt = (three_mode == 2'h0 && three_rise) || // see RULE8
                         (three_mode == 2'h1 && three_fall) ||
                         (three_mode == 2'h2 && (three_rise || three_fall));
  assign ext_zero_evt  = ext_zero_pin_enable && !sync2_reg[0] && prev_reg[0]; // see RULE7
  assign ext_five_fall = !sync2_reg[3] && prev_reg[3];
  // Level mode wakes once the pin rises; edge mode wakes on a falling edge.
  assign wake_pin = mode_reg[`IPM_MODE_WAKE_EDGE] ? ext_five_fall : sync2_reg[3]; // see RULE17

  assign mask3 = {6'h00, 1'b1, ext_zero_pin_enable};
  assign pend_any = |(flag1_reg & mask1_reg) | // see RULE23
                    |(flag2_reg & mask2_reg) |
                    |(flag3_reg & mask3);
  assign irq_req = pend_any && global_irq_en; // see RULE13, RULE16

  assign core_halt  = state_reg != `IPM_ST_NORMAL; // see RULE15
  assign osc_run    = state_reg != `IPM_ST_SLEEP; // see RULE17
  assign periph_run = state_reg == `IPM_ST_NORMAL || state_reg == `IPM_ST_IDLE;
  assign warm_last  = WARM_LAST_I[`IPM_WARM_W-1:0];

  // Two flops bring each pin into the clock domain; a third keeps the last level for edges.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      prev_reg  <= 4'hF;
    end else begin
      sync1_reg <= {ext_five_pin_n, ext_three_pin, ext_one_pin, ext_zero_pin_n};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // A pin level is accepted only after it has differed for the full filter count.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      one_lvl_reg    <= 1'b0;
      one_prev_reg   <= 1'b0;
      one_cnt_reg    <= 6'h00;
      three_lvl_reg  <= 1'b0;
      three_prev_reg <= 1'b0;
      three_cnt_reg  <= 6'h00;
    end else begin
      one_cnt_reg    <= flt_next(one_cnt_reg, one_diff, one_lim); // see RULE6
      three_cnt_reg  <= flt_next(three_cnt_reg, three_diff, `IPM_FLT_THREE); // see RULE10
      one_prev_reg   <= one_lvl_reg;
      three_prev_reg <= three_lvl_reg;
      if (one_take) begin
        one_lvl_reg <= sync2_reg[1];
      end
      if (three_take) begin
        three_lvl_reg <= sync2_reg[2];
      end
    end
  end

  // Hardware events are gathered here; an event in the cycle of a software clear wins.
  always @* begin
    set1 = periph_evt_first & `IPM_P1_SRC;
    set1[`IPM_F1_EXT5] = ext_five_fall; // see RULE13
    set1[`IPM_F1_EXT3] = ext_three_evt; // see RULE8
    set2 = periph_evt_second & `IPM_P2_SRC;
    set2[`IPM_F2_EXT1] = ext_one_evt; // see RULE9
    set3 = 8'h00;
    set3[`IPM_F3_EXT0] = ext_zero_evt;
    set3[`IPM_F3_WDT] = wdt_timeout && watchdog_on && !core_reg[`IPM_CORE_WDT_ACT]; // see RULE1
    flag1_next = flag_next(flag1_reg, wr_f1, reg_wdata, `IPM_MASK1_WMASK, set1); // see RULE22
    flag2_next = flag_next(flag2_reg, wr_f2, reg_wdata, `IPM_MASK2_WMASK, set2); // see RULE22
    flag3_next = flag_next(flag3_reg, wr_f3, reg_wdata, `IPM_FLAG3_WMASK, set3); // see RULE22
  end

  always @* begin
    gie_next = core_reg[`IPM_CORE_GIE];
    if (wr_core) begin
      gie_next = reg_wdata[`IPM_CORE_GIE];
    end
    if (irq_on_instruction || irq_return_instruction) begin
      gie_next = 1'b1; // see RULE2
    end
    if (irq_off_instruction || irq_entry) begin
      gie_next = 1'b0; // see RULE2
    end
  end

  // Normal, Idle, Sleep and warm-up; a reset always returns to Normal.
  always @* begin
    state_next = state_reg;
    warm_next  = warm_reg;
    case (state_reg)
      `IPM_ST_NORMAL: begin
        if (power_down_instruction) begin
          // Entry does not look at the wake pin level.
          state_next = mode_reg[`IPM_MODE_SLEEP_SEL] ? `IPM_ST_SLEEP : `IPM_ST_IDLE; // see RULE14
        end
      end
      `IPM_ST_IDLE: begin
        if (pend_any) begin
          state_next = `IPM_ST_NORMAL; // see RULE15
        end
      end
      `IPM_ST_SLEEP: begin
        if (wake_pin) begin
          state_next = `IPM_ST_WARM; // see RULE20
          warm_next  = {`IPM_WARM_W{1'b0}};
        end
      end
      `IPM_ST_WARM: begin
        if (warm_reg >= warm_last) begin
          state_next = `IPM_ST_NORMAL; // see RULE18
        end else begin
          warm_next = warm_reg + 1'b1; // see RULE24
        end
      end
      default: begin
        state_next = `IPM_ST_NORMAL;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= `IPM_ST_NORMAL; // see RULE21
      warm_reg  <= {`IPM_WARM_W{1'b0}};
    end else begin
      state_reg <= state_next;
      warm_reg  <= warm_next;
    end
  end

  // Instructions override a register write of the global enable bit.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      core_reg      <= `IPM_CORE_RST;
      mode_reg      <= `IPM_MODE_RST;
      ext_reg       <= `IPM_EXT_RST;
      mask1_reg     <= `IPM_MASK_RST;
      mask2_reg     <= `IPM_MASK_RST;
      flag1_reg     <= 8'h00;
      flag2_reg     <= 8'h00;
      flag3_reg     <= 8'h00;
      wdt_reset_req <= 1'b0;
    end else begin
      if (wr_core) begin
        core_reg <= reg_wdata;
      end
      core_reg[`IPM_CORE_GIE] <= gie_next;
      if (wr_mode) begin
        mode_reg <= (reg_wdata & `IPM_MODE_WMASK) | `IPM_MODE_FIXED;
      end
      if (wr_ext) begin
        ext_reg <= reg_wdata & `IPM_EXT_WMASK;
      end
      if (wr_m1) begin
        mask1_reg <= reg_wdata & `IPM_MASK1_WMASK; // see RULE11
      end
      if (wr_m2) begin
        mask2_reg <= reg_wdata & `IPM_MASK2_WMASK; // see RULE12
      end
      flag1_reg     <= flag1_next;
      flag2_reg     <= flag2_next;
      flag3_reg     <= flag3_next;
      wdt_reset_req <= wdt_timeout && watchdog_on && core_reg[`IPM_CORE_WDT_ACT]; // see RULE1
    end
  end

  always @* begin
    case (reg_addr)
      `IPM_A_CORE:  rd_mux = core_reg;
      `IPM_A_MODE:  rd_mux = mode_reg;
      `IPM_A_EXT:   rd_mux = ext_reg;
      `IPM_A_MASK1: rd_mux = mask1_reg;
      `IPM_A_MASK2: rd_mux = mask2_reg;
      `IPM_A_FLAG1: rd_mux = flag1_reg;
      `IPM_A_FLAG2: rd_mux = flag2_reg;
      `IPM_A_FLAG3: rd_mux = flag3_reg;
      default:      rd_mux = 8'h00;
    endcase
  end

  // Read data stand for the cycle after the read strobe and are zero otherwise.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // ipm_ctrl

// ---- ipm_defines.vh ----
// Register offsets, field positions, reset values and timing counts of the interrupt and mode block.
`ifndef IPM_DEFINES_VH
`define IPM_DEFINES_VH
`define IPM_AW 5
`define IPM_A_CORE 5'h00
`define IPM_A_MODE 5'h05
`define IPM_A_EXT 5'h0B
`define IPM_A_MASK1 5'h0E
`define IPM_A_MASK2 5'h0F
`define IPM_A_FLAG1 5'h10
`define IPM_A_FLAG2 5'h11
`define IPM_A_FLAG3 5'h12
`define IPM_CORE_RST 8'h00
`define IPM_MODE_RST 8'h04
`define IPM_EXT_RST 8'h00
`define IPM_MASK_RST 8'h00
`define IPM_CORE_WDT_ACT 7
`define IPM_CORE_GIE 6
`define IPM_CORE_WDT_ON 3
`define IPM_MODE_SLEEP_SEL 1
`define IPM_MODE_WAKE_EDGE 0
`define IPM_MODE_WMASK 8'h73
`define IPM_MODE_FIXED 8'h04
`define IPM_EXT_ONE_FILT 7
`define IPM_EXT_ZERO_EN 6
`define IPM_EXT_ONE_EDGE 1
`define IPM_EXT_WMASK 8'hDB
`define IPM_MASK1_WMASK 8'hEF
`define IPM_MASK2_WMASK 8'h7D
`define IPM_FLAG3_WMASK 8'h03
`define IPM_P1_SRC 8'h67
`define IPM_P2_SRC 8'h79
`define IPM_F1_EXT5 7
`define IPM_F1_EXT3 3
`define IPM_F2_EXT1 2
`define IPM_F3_EXT0 0
`define IPM_F3_WDT 1
`define IPM_FLT_ONE_LONG 6'h3F
`define IPM_FLT_ONE_SHORT 6'h0F
`define IPM_FLT_THREE 6'h07
`define IPM_WARM_CYCLES 16
`define IPM_WARM_W 16
`define IPM_ST_NORMAL 2'h0
`define IPM_ST_IDLE 2'h1
`define IPM_ST_SLEEP 2'h2
`define IPM_ST_WARM 2'h3
`endif

// ---- ipm_ctrl_sva.sv ----
// Assertion checker for the interrupt and power mode block.
`timescale 1ns/1ps
module ipm_chk #(
  parameter WARM_CYCLES = 16
) (
  input wire       core_clk,
  input wire       sys_rst,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       irq_on_instruction,
  input wire       irq_off_instruction,
  input wire       irq_return_instruction,
  input wire       power_down_instruction,
  input wire       irq_entry,
  input wire       wdt_timeout,
  input wire       irq_req,
  input wire       global_irq_en,
  input wire       wdt_reset_req,
  input wire       watchdog_on,
  input wire [3:0] watchdog_div_log2,
  input wire [3:0] timer_div_log2,
  input wire       core_halt,
  input wire       osc_run,
  input wire       periph_run
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  gie_off_a: assert property (irq_off_instruction || irq_entry |=> !global_irq_en)
    else $error("global enable not cleared");
  gie_on_a: assert property ((irq_on_instruction || irq_return_instruction)
    && !irq_off_instruction && !irq_entry |=> global_irq_en)
    else $error("global enable not set");
  req_gate_a: assert property (irq_req |-> global_irq_en)
    else $error("request without global enable");
  wdt_reset_a: assert property (wdt_reset_req |-> $past(wdt_timeout) && $past(watchdog_on))
    else $error("watchdog reset without cause");
  wdt_div_a: assert property (watchdog_div_log2[0] == 1'b0 && watchdog_div_log2 >= 4'h2
    && watchdog_div_log2 <= 4'h8) else $error("watchdog ratio out of set");
  timer_div_a: assert property (timer_div_log2 >= 4'h1 && timer_div_log2 <= 4'h8)
    else $error("timer ratio out of set");
  halt_cause_a: assert property ($rose(core_halt) |-> $past(power_down_instruction))
    else $error("halt without power down");
  sleep_stop_a: assert property (!osc_run |-> core_halt && !periph_run)
    else $error("activity while oscillator stopped");
  warm_hold_a: assert property ($rose(osc_run) |-> core_halt)
    else $error("execution resumed without warm-up");
  cover property (!osc_run);
  cover property (core_halt && osc_run);
  cover property (wdt_reset_req);
  cover property (irq_entry);
endmodule // ipm_chk

bind ipm_ctrl ipm_chk #(.WARM_CYCLES(WARM_CYCLES)) i_chk (.core_clk, .sys_rst, .reg_rd,
  .reg_rdata, .irq_on_instruction, .irq_off_instruction, .irq_return_instruction,
  .power_down_instruction, .irq_entry, .wdt_timeout, .irq_req, .global_irq_en,
  .wdt_reset_req, .watchdog_on, .watchdog_div_log2, .timer_div_log2, .core_halt,
  .osc_run, .periph_run);

// ---- ipm_core_model.sv ----
// Behavioural processor core that enters the interrupt vector on request.
`timescale 1ns/1ps
module ipm_core_model (
  input  wire core_clk,
  input  wire sys_rst,
  input  wire irq_req,
  input  wire core_halt,
  output reg  irq_entry
);
  // A halted core takes no vector; entry lasts one cycle.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_entry <= 1'b0;
    end else begin
      irq_entry <= irq_req && !core_halt && !irq_entry;
    end
  end
endmodule // ipm_core_model

// ---- test_ipm_ctrl.sv ----
// Self-checking bench for the interrupt and power mode block.
`timescale 1ns/1ps
`include "ipm_defines.vh"
module test_ipm_ctrl;
  localparam WARM = 4;
  reg        core_clk, sys_rst, reg_wr, reg_rd, wdt, p0, p5;
  reg  [4:0] reg_addr;
  reg  [7:0] reg_wdata, ev1, ev2;
  reg  [3:0] ins, i;
  reg  [1:0] pk;
  wire [7:0] reg_rdata;
  wire [3:0] wdv, tdv;
  wire [2:0] csel;
  wire       irq_req, gie, wrst, won, halt, osc, irq_entry, zen, prun;
  integer    err_total, check_count, cnt, n;
  ipm_ctrl #(.WARM_CYCLES(WARM)) i_dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq_on_instruction(ins[0]), .irq_off_instruction(ins[1]),
    .irq_return_instruction(ins[2]), .power_down_instruction(ins[3]), .irq_entry,
    .periph_evt_first(ev1), .periph_evt_second(ev2), .wdt_timeout(wdt),
    .ext_zero_pin_n(p0), .ext_one_pin(pk[0]), .ext_three_pin(pk[1]), .ext_five_pin_n(p5),
    .irq_req, .global_irq_en(gie), .wdt_reset_req(wrst), .watchdog_on(won),
    .watchdog_div_log2(wdv), .timer_div_log2(tdv), .ext_zero_pin_enable(zen),
    .clock_source_sel(csel), .core_halt(halt), .osc_run(osc), .periph_run(prun));
  ipm_core_model i_core (.core_clk, .sys_rst, .irq_req, .core_halt(halt), .irq_entry);
  always #50 core_clk = ~core_clk;
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  always @(posedge core_clk) begin
    cnt = cnt + 1;
    if (cnt == 30000) begin
      err_total = err_total + 1;
      conclude;
    end
  end
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer k);
    begin
      repeat (k) @(posedge core_clk);
      #1;
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [7:0] e, input string nm);
    begin
      @(posedge core_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      cyc(1);
      reg_rd <= 1'b0;
      chk(nm, e, reg_rdata);
    end
  endtask
  task ip(input [3:0] v);
    begin
      @(posedge core_clk); ins <= v;
      cyc(1); ins <= 4'h0;
      cyc(1);
    end
  endtask
  task pls(input [1:0] m, input integer w);
    begin
      @(posedge core_clk); pk <= m;
      repeat (w) @(posedge core_clk);
      pk <= 2'b00;
      cyc(70);
    end
  endtask
  task t_regs;
    begin
      rd(`IPM_A_MODE, 8'h04, "mode reset");
      rd(`IPM_A_CORE, 8'h00, "core reset");
      wr(`IPM_A_MASK1, 8'hFF); rd(`IPM_A_MASK1, 8'hEF, "mask1");
      wr(`IPM_A_MASK2, 8'hFF); rd(`IPM_A_MASK2, 8'h7D, "mask2");
      wr(`IPM_A_EXT, 8'hFF); rd(`IPM_A_EXT, 8'hDB, "ext ctl");
      wr(`IPM_A_MODE, 8'hFF); rd(`IPM_A_MODE, 8'h77, "mode");
      chk("clock source", 8'h07, csel);
      wr(5'h1F, 8'hFF); rd(5'h1F, 8'h00, "unmapped");
      wr(`IPM_A_MASK1, 0); wr(`IPM_A_MASK2, 0); wr(`IPM_A_EXT, 0); wr(`IPM_A_MODE, 0);
    end
  endtask
  task t_div;
    for (i = 0; i < 8; i = i + 1) begin
      wr(`IPM_A_CORE, {2'b00, i[1:0], i[0], i[2:0]});
      cyc(1);
      chk("timer div", i + 1, tdv);
      chk("wdt div", 2 + 2 * i[1:0], wdv);
      chk("wdt on", i[0], won);
    end
  endtask
  task t_gie;
    begin
      ip(4'h1); chk("gie on", 1, gie);
      ip(4'h2); chk("gie off", 0, gie);
      ip(4'h4); chk("gie ret", 1, gie);
      ip(4'h3); chk("gie clr win", 0, gie);
    end
  endtask
  task t_pin5;
    begin
      wr(`IPM_A_FLAG1, 0); ip(4'h1); p5 <= 1'b0;
      cyc(6); rd(`IPM_A_FLAG1, 8'h80, "pin5 flag");
      chk("masked req", 0, irq_req);
      wr(`IPM_A_MASK1, 8'h80); cyc(3);
      chk("entry clears gie", 0, gie);
      p5 <= 1'b1; wr(`IPM_A_MASK1, 0); wr(`IPM_A_FLAG1, 0);
    end
  endtask
  task t_pin1;
    begin
      wr(`IPM_A_EXT, 8'h80);
      @(posedge core_clk); ev2 <= 8'hFF;
      cyc(1); ev2 <= 8'h00;
      rd(`IPM_A_FLAG2, 8'h79, "periph flags");
      wr(`IPM_A_FLAG2, 0);
      pls(2'b01, 12); rd(`IPM_A_FLAG2, 8'h00, "pin1 short");
      pls(2'b01, 20); rd(`IPM_A_FLAG2, 8'h04, "pin1 long");
      wr(`IPM_A_EXT, 8'h00); wr(`IPM_A_FLAG2, 0);
      pls(2'b01, 40); rd(`IPM_A_FLAG2, 8'h00, "pin1 63 filter");
    end
  endtask
  task t_pin3;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(`IPM_A_EXT, {3'b000, i[1:0], 3'b000}); wr(`IPM_A_FLAG1, 0);
        pls(2'b10, 12); rd(`IPM_A_FLAG1, (i == 3) ? 8'h00 : 8'h08, "pin3 edge");
      end
      wr(`IPM_A_EXT, 8'h08); wr(`IPM_A_FLAG1, 0);
      pls(2'b10, 5); rd(`IPM_A_FLAG1, 8'h00, "pin3 filter");
    end
  endtask
  task t_wdt_pin0;
    begin
      wr(`IPM_A_CORE, 8'h88);
      @(posedge core_clk); wdt <= 1'b1;
      cyc(1); wdt <= 1'b0;
      chk("wdt reset", 1, wrst);
      cyc(1); chk("wdt reset pulse", 0, wrst);
      wr(`IPM_A_CORE, 8'h08); wr(`IPM_A_FLAG3, 0);
      @(posedge core_clk); wdt <= 1'b1;
      cyc(1); wdt <= 1'b0;
      chk("no reset", 0, wrst);
      rd(`IPM_A_FLAG3, 8'h02, "wdt flag");
      for (i = 0; i < 2; i = i + 1) begin
        wr(`IPM_A_EXT, i[0] ? 8'h40 : 8'h00); wr(`IPM_A_FLAG3, 0);
        p0 <= 1'b0; cyc(6); rd(`IPM_A_FLAG3, {7'h00, i[0]}, "pin0 flag");
        chk("pin0 enable", i[0], zen);
        p0 <= 1'b1; cyc(4);
      end
      wr(`IPM_A_EXT, 0); wr(`IPM_A_FLAG3, 0);
    end
  endtask
  task t_modes;
    begin
      wr(`IPM_A_MASK1, 8'h02); wr(`IPM_A_FLAG1, 0);
      ip(4'h8); chk("idle halt", 1, halt); chk("idle osc", 1, osc);
      chk("idle periph", 1, prun);
      @(posedge core_clk); ev1 <= 8'h02;
      cyc(1); ev1 <= 8'h00;
      cyc(3); chk("idle wake", 0, halt); chk("no vector", 0, gie);
      wr(`IPM_A_FLAG1, 0); ip(4'h1); ip(4'h8);
      chk("idle gie", 1, gie); chk("idle halt gie", 1, halt);
      @(posedge core_clk); ev1 <= 8'h02;
      cyc(1); ev1 <= 8'h00;
      cyc(4); chk("idle vector", 0, gie);
      wr(`IPM_A_FLAG1, 0); wr(`IPM_A_MODE, 8'h03);
      ip(4'h8); chk("sleep osc", 0, osc);
      chk("sleep periph", 0, prun);
      @(posedge core_clk); ev1 <= 8'h02;
      cyc(1); ev1 <= 8'h00;
      cyc(4); chk("no event wake", 1, halt);
      p5 <= 1'b0; n = 0;
      while (halt && n < 50) begin
        cyc(1); n = n + 1;
      end
      chk("warm-up", 1, n >= WARM && n <= WARM + 5);
      p5 <= 1'b1; cyc(3);
      wr(`IPM_A_MODE, 8'h02); p5 <= 1'b0; cyc(3);
      ip(4'h8); chk("level sleep", 0, osc);
      cyc(4); chk("level hold", 0, osc);
      p5 <= 1'b1; cyc(12); chk("level wake", 0, halt);
      wr(`IPM_A_MODE, 8'h03);
      ip(4'h8); chk("sleep again", 0, osc);
      sys_rst <= 1'b1; cyc(3); sys_rst <= 1'b0;
      cyc(1); chk("reset wake", 0, halt);
      rd(`IPM_A_MODE, 8'h04, "mode after reset");
    end
  endtask
  initial begin
    core_clk = 0; sys_rst = 1; reg_wr = 0; reg_rd = 0; wdt = 0; p0 = 1; p5 = 1;
    reg_addr = 0; reg_wdata = 0; ev1 = 0; ev2 = 0; ins = 0; pk = 0;
    err_total = 0; check_count = 0; cnt = 0;
    cyc(20); sys_rst <= 1'b0;
    t_regs; t_div; t_gie; t_pin5; t_pin1; t_pin3; t_wdt_pin0; t_modes;
    conclude;
  end
endmodule // test_ipm_ctrl
